// ### src/spt_pattern_trigger.sv
/*
  Pattern generator request and output control.
  Assumes clk is the generator input clock and that the serial port outside
  presents byte writes and reads on reg_* with addresses already decoded.
*/
`timescale 1ns/1ns
module spt_pattern_trigger (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        reg_wr,
  input  wire logic [spt_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        pattern_request_pin,
  output logic                             sysref_out,
  output logic                             busy
);
  spt_pkg::spt_regs_t  regs,     next_regs;
  spt_pkg::spt_state_t state,    next_state;
  logic [15:0]         div_cnt,  next_div_cnt;
  logic [3:0]          pulses,   next_pulses;
  logic                pend,     next_pend;
  logic                out_q,    next_out_q;
  logic [7:0]          rdata,    next_rdata;
  logic                pin_s1;
  logic                pin_s2;
  logic                pin_d;

  logic [15:0] width;
  logic [1:0]  gen_mode;
  logic [3:0]  n_pulses;
  logic        src_pin;
  logic        edge_mode;
  logic        trig_bit;
  logic        tick;
  logic        active_edge;
  logic        start_evt;
  logic        hold_level;
  // synchronised pin edges, the sequencer's self-clear strobe to the register file and its next busy value
  logic        pin_rise;
  logic        pin_fall;
  logic        self_clear;
  logic        next_busy;

  assign width     = {regs.width_hi, regs.width_lo};
  assign gen_mode  = regs.mode_cfg[spt_pkg::GEN_MODE_HI:spt_pkg::GEN_MODE_LO];
  assign n_pulses  = spt_pkg::spt_nshot(
                       regs.mode_cfg[spt_pkg::NSHOT_HI:spt_pkg::NSHOT_LO]);
  assign src_pin   = regs.req_ctrl[spt_pkg::BIT_SRC_PIN];
  assign edge_mode = regs.req_ctrl[spt_pkg::BIT_EDGE_MODE];
  assign trig_bit  = regs.req_ctrl[spt_pkg::BIT_TRIGGER];

  // zero width behaves as one so the divider never stalls
  assign tick = (width == 16'h0000) || (div_cnt >= width - spt_pkg::WIDTH_ONE);

  // pin_d is one cycle older than pin_s2, so these see the synchronised pin move
  assign pin_rise    = ~pin_d & pin_s2;
  assign pin_fall    = pin_d & ~pin_s2;

  // trigger bit clear picks the rising edge, set picks the falling edge
  assign active_edge = trig_bit ? pin_fall : pin_rise;

  // software mode is always level sensitive, edge bit ignored there
  always_comb begin
    if (!src_pin) begin
      start_evt  = trig_bit;
      hold_level = trig_bit;
    end else if (!edge_mode) begin
      start_evt  = pin_rise;
      hold_level = pin_s2;
    end else begin
      start_evt  = active_edge;
      hold_level = 1'b1;
    end
  end

  always_comb begin
    self_clear   = 1'b0;
    next_state   = state;
    next_pulses  = pulses;
    next_pend    = pend;
    next_out_q   = out_q;
    next_div_cnt = tick ? 16'h0000 : div_cnt + spt_pkg::WIDTH_ONE;
    // requests only count while idle, so early edges are lost
    if (state == spt_pkg::SPT_IDLE && start_evt &&
        (gen_mode == spt_pkg::GEN_BURST || gen_mode == spt_pkg::GEN_CONT)) begin
      next_pend = 1'b1;
    end
    // level requests withdrawn before the boundary are dropped
    if (state == spt_pkg::SPT_IDLE && !hold_level && !(src_pin && edge_mode)) begin
      next_pend = 1'b0;
    end
    if (gen_mode == spt_pkg::GEN_STOP || gen_mode == spt_pkg::GEN_PRBS) begin
      next_state = spt_pkg::SPT_IDLE;
      next_out_q = 1'b0;
      next_pend  = 1'b0;
    end else if (tick) begin
      case (state)
        spt_pkg::SPT_IDLE: begin
          next_out_q = 1'b0;
          if (pend) begin
            next_state  = spt_pkg::SPT_RUN;
            next_out_q  = 1'b1;
            next_pulses = 4'h0;
            next_pend   = 1'b0;
          end
        end
        spt_pkg::SPT_RUN: begin
          if (out_q) begin
            next_out_q  = 1'b0;
            next_pulses = pulses + spt_pkg::COUNT_ONE;
            if (gen_mode == spt_pkg::GEN_BURST &&
                pulses + spt_pkg::COUNT_ONE >= n_pulses) begin
              next_state = spt_pkg::SPT_IDLE;
              if (!src_pin) begin
                self_clear = 1'b1;
              end
            end
          end else if (gen_mode == spt_pkg::GEN_CONT && !hold_level) begin
            next_state = spt_pkg::SPT_IDLE;
          end else if (gen_mode == spt_pkg::GEN_CONT ||
                       pulses < n_pulses) begin
            next_out_q = 1'b1;
          end else begin
            next_state = spt_pkg::SPT_IDLE;
          end
        end
        default: begin
          next_state = spt_pkg::SPT_IDLE;
          next_out_q = 1'b0;
        end
      endcase
    end
  end

  // busy follows the state being entered, so it rises with the first pulse
  assign next_busy = (next_state == spt_pkg::SPT_RUN);

  // software write lands after the self-clear, so a new set wins
  always_comb begin
    next_regs = regs;
    if (self_clear) begin
      next_regs.req_ctrl[spt_pkg::BIT_TRIGGER] = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        spt_pkg::OFS_WIDTH_LO: next_regs.width_lo = reg_wdata;
        spt_pkg::OFS_WIDTH_HI: next_regs.width_hi = reg_wdata;
        spt_pkg::OFS_REQ_CTRL: next_regs.req_ctrl = reg_wdata;
        spt_pkg::OFS_MODE_CFG: next_regs.mode_cfg = reg_wdata;
        default: ;
      endcase
    end
  end

  // unmapped addresses read as zero

  always_comb begin
    case (reg_addr)
      spt_pkg::OFS_WIDTH_LO: next_rdata = regs.width_lo;
      spt_pkg::OFS_WIDTH_HI: next_rdata = regs.width_hi;
      spt_pkg::OFS_REQ_CTRL: next_rdata = regs.req_ctrl;
      spt_pkg::OFS_MODE_CFG: next_rdata = regs.mode_cfg;
      default:               next_rdata = 8'h00;
    endcase
  end

  // pin_s1 is read only by pin_s2
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_d  <= 1'b0;
    end else begin
      pin_s1 <= pattern_request_pin;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regs.width_lo <= spt_pkg::RST_WIDTH_LO;
      regs.width_hi <= spt_pkg::RST_WIDTH_HI;
      regs.req_ctrl <= spt_pkg::RST_REQ_CTRL;
      regs.mode_cfg <= spt_pkg::RST_MODE_CFG;
    end else begin
      regs <= next_regs;
    end
  end

  // divider never stops, so a started sequence lands on the common output grid
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state   <= spt_pkg::SPT_IDLE;
      div_cnt <= 16'h0000;
      pulses  <= 4'h0;
      pend    <= 1'b0;
      out_q   <= 1'b0;
      busy    <= 1'b0;
    end else begin
      state   <= next_state;
      div_cnt <= next_div_cnt;
      pulses  <= next_pulses;
      pend    <= next_pend;
      out_q   <= next_out_q;
      busy    <= next_busy;
    end
  end

  // read data registered: one cycle of latency on every read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign sysref_out = out_q;
  assign reg_rdata  = rdata;
endmodule

// ### src/spt_pkg.sv
/*
  Constants, register layout and types for the pattern trigger controller.
  Assumes one generator clock and a simple byte-wide register port.
*/
// Functional notes
// - software mode: trigger bit acts as level
// - software burst: bit set starts, self-clears after N
// - software continuous: runs while bit set
// - pin level burst: rise starts, pin released after
// - pin level continuous: rise starts, low stops
// - edge mode: trigger bit selects active pin edge
// - edge burst: pin release cannot cut burst
// - edges during a running sequence are dropped
// - edge continuous: edge starts, runs until mode changes
// - mode field selects burst, continuous, prbs, stop; prbs holds output low like stop
// - stop mode holds output low
// - burst count field decodes pulse count
// - after burst, output low until next request
// - continuous output toggles, period twice width divider
// - sixteen-bit width divider over two registers
// - source select bit picks software or pin
// - pulses start only on divider boundaries
package spt_pkg;
  localparam int          ADDR_W         = 13;
  localparam logic [12:0] OFS_WIDTH_LO   = 13'h0400;
  localparam logic [12:0] OFS_WIDTH_HI   = 13'h0401;
  localparam logic [12:0] OFS_REQ_CTRL   = 13'h0402;
  localparam logic [12:0] OFS_MODE_CFG   = 13'h0403;
  localparam logic [7:0]  RST_WIDTH_LO   = 8'h01;
  localparam logic [7:0]  RST_WIDTH_HI   = 8'h00;
  localparam logic [7:0]  RST_REQ_CTRL   = 8'h00;
  localparam logic [7:0]  RST_MODE_CFG   = 8'h30;
  localparam int          BIT_SRC_PIN    = 7;
  localparam int          BIT_EDGE_MODE  = 6;
  localparam int          BIT_TRIGGER    = 5;
  localparam int          GEN_MODE_HI    = 5;
  localparam int          GEN_MODE_LO    = 4;
  localparam int          NSHOT_HI       = 3;
  localparam int          NSHOT_LO       = 1;
  localparam logic [1:0]  GEN_BURST      = 2'h0;
  localparam logic [1:0]  GEN_CONT       = 2'h1;
  localparam logic [1:0]  GEN_PRBS       = 2'h2;
  localparam logic [1:0]  GEN_STOP       = 2'h3;
  localparam logic [15:0] WIDTH_ONE      = 16'h0001;
  localparam logic [3:0]  COUNT_ONE      = 4'h1;

  typedef enum logic [0:0] {
    SPT_IDLE = 1'b0,
    SPT_RUN  = 1'b1
  } spt_state_t;

  typedef struct packed {
    logic [7:0] width_lo;
    logic [7:0] width_hi;
    logic [7:0] req_ctrl;
    logic [7:0] mode_cfg;
  } spt_regs_t;

  // burst count decode; unused codes give a single pulse
  function automatic logic [3:0] spt_nshot(input logic [2:0] code);
    case (code)
      3'h2:    spt_nshot = 4'h2;
      3'h3:    spt_nshot = 4'h4;
      3'h4:    spt_nshot = 4'h6;
      3'h5:    spt_nshot = 4'h8;
      default: spt_nshot = 4'h1;
    endcase
  endfunction
endpackage

// ### bench/spt_pattern_trigger_asserts.sv
/*
  Port checker for the pattern trigger controller.
  Assumes it is bound to the top module and that K stays 2 while pulses run.
*/
`timescale 1ns/1ns
module spt_pattern_trigger_asserts (
  input wire logic                       clk,
  input wire logic                       arst_n,
  input wire logic                       reg_wr,
  input wire logic [spt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       pattern_request_pin,
  input wire logic                       sysref_out,
  input wire logic                       busy
);
  localparam logic [3:0] NTAB [8] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'h1, 4'h1};
  logic [7:0] mode_q;
  logic [7:0] klo;
  logic [7:0] khi;
  logic [3:0] npl;
  logic       k2;
  logic [1:0] rq_q;
  assign k2 = ({khi, klo} == 16'h0002);
  // shadow of the written registers, so timing rules can be tied to K and mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 8'h30;
      klo <= 8'h01;
      khi <= 8'h00;
      npl <= 4'h0;
      rq_q <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == 13'h0403) mode_q <= reg_wdata;
      if (reg_wr && reg_addr == 13'h0400) klo <= reg_wdata;
      if (reg_wr && reg_addr == 13'h0401) khi <= reg_wdata;
      if (reg_wr && reg_addr == 13'h0402) rq_q <= reg_wdata[7:6];
      npl <= busy ? npl + {3'h0, $rose(sysref_out)} : 4'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_stop; mode_q[5] |=> !sysref_out && !busy; endproperty
  a_stop: assert property (p_stop) else $error("output active in stop mode");
  property p_busy; sysref_out |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("pulse outside a sequence");
  property p_start; $rose(busy) |-> $rose(sysref_out); endproperty
  a_start: assert property (p_start) else $error("sequence start off pulse");
  property p_high; $rose(sysref_out) && k2 && !mode_q[5] |=> sysref_out ##1 !sysref_out; endproperty
  a_high: assert property (p_high) else $error("high half not K");
  property p_low; $fell(sysref_out) && k2 |=> !sysref_out; endproperty
  a_low: assert property (p_low) else $error("low half short");
  property p_count; $fell(busy) && mode_q[5:4] == 2'h0 |-> npl == NTAB[mode_q[3:1]]; endproperty
  a_count: assert property (p_count) else $error("burst pulse count");
  property p_rdmode; reg_addr == 13'h0403 |=> reg_rdata == $past(mode_q); endproperty
  a_rdmode: assert property (p_rdmode) else $error("mode readback");
  // level pin mode only: an edge or software request may already be pending
  property p_sync;
    rq_q == 2'h2 && $rose(pattern_request_pin) && !$past(pattern_request_pin, 2) &&
      !$past(pattern_request_pin, 3) && !busy |=> !sysref_out [*3];
  endproperty
  a_sync: assert property (p_sync) else $error("pin request too fast");
endmodule
bind spt_pattern_trigger spt_pattern_trigger_asserts i_chk (.clk(clk), .arst_n(arst_n),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .pattern_request_pin(pattern_request_pin), .sysref_out(sysref_out), .busy(busy));

// ### bench/spt_host_model.sv
/*
  Host model for the request pin.
  Assumes the bench gives the wanted level; the pin moves off the clock edge.
*/
`timescale 1ns/1ns
module spt_host_model (
  input  wire logic clk,
  input  wire logic want,
  output logic      pattern_request_pin
);
  // offset from the edge, as an unrelated source would be
  always @(posedge clk) pattern_request_pin <= #3 want;
endmodule

// ### bench/spt_pattern_trigger_tb_top.sv
/*
  Self-checking bench for the pattern trigger controller.
  Assumes the host model drives the pin and registers are reached on reg_*.
*/
`timescale 1ns/1ns
module spt_pattern_trigger_tb_top;
  logic        clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, want = 1'h0;
  logic [12:0] reg_addr = 13'h0000;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        pin, sysref_out, busy;
  int          n_fail = 0, cmp_count = 0;
  spt_pattern_trigger i_dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pattern_request_pin(pin),
    .sysref_out(sysref_out), .busy(busy));
  spt_host_model i_host (.clk(clk), .want(want), .pattern_request_pin(pin));
  initial forever #5 clk = ~clk;
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
    cmp_count++;
    if (v !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", s, e, v);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    step(1);
    reg_wr = 1'h0;
    step(1);
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] v);
    reg_addr = a;
    step(2);
    v = reg_rdata;
  endtask
  // counts new pulses until the sequence ends, or until lim pulses are seen
  task automatic run(input int lim, output int c);
    logic p, s;
    c = 0;
    s = 1'h0;
    p = (sysref_out === 1'h1);
    for (int i = 0; i < 400; i++) begin
      step(1);
      if (sysref_out === 1'h1 && !p) c++;
      p = (sysref_out === 1'h1);
      s |= (busy === 1'h1);
      if ((s && busy === 1'h0) || c == lim) return;
    end
    n_fail++;
    end_sim();
  endtask
  task automatic quiet(input int n);
    logic a = 1'h0;
    repeat (n) begin
      step(1);
      a |= busy | sysref_out;
    end
    chk("idle", 8'h00, {7'h00, a});
  endtask
  task automatic t_regs;
    logic [7:0] v;
    logic [7:0] e [5] = '{8'h01, 8'h00, 8'h00, 8'h30, 8'h00};
    wr(13'h0404, 8'hFF);
    for (int a = 0; a < 5; a++) begin
      rd(13'h0400 + 13'(a), v);
      chk("reset value", e[a], v);
    end
    wr(13'h0402, 8'h5A);
    rd(13'h0402, v);
    chk("req_ctrl", 8'h5A, v);
    wr(13'h0402, 8'h00);
    wr(13'h0400, 8'h02);
  endtask
  task automatic t_sw_burst;
    int c;
    logic [7:0] v;
    int n [8] = '{1, 1, 2, 4, 6, 8, 1, 1};
    for (int k = 0; k < 8; k++) begin
      wr(13'h0403, 8'(k * 2));
      wr(13'h0402, 8'h20);
      run(99, c);
      chk("pulses", 8'(n[k]), 8'(c));
      rd(13'h0402, v);
      chk("self clear", 8'h00, v);
    end
    wr(13'h0403, 8'h20);
    wr(13'h0402, 8'h20);
    quiet(30);
    wr(13'h0402, 8'h00);
  endtask
  task automatic t_cont(input logic [7:0] rq);
    int c;
    wr(13'h0403, 8'h10);
    if (rq[7]) want = 1'h1;
    else wr(13'h0402, 8'h20);
    run(5, c);
    chk("running", 8'h01, {7'h00, busy});
    if (rq[7]) want = 1'h0;
    else wr(13'h0402, 8'h00);
    run(99, c);
    chk("tail", 8'h01, {7'h00, c <= 1});
    quiet(20);
  endtask
  task automatic t_pin_level;
    int c;
    wr(13'h0402, 8'h80);
    wr(13'h0403, 8'h04);
    want = 1'h1;
    run(99, c);
    chk("pin burst", 8'h02, 8'(c));
    quiet(20);
    want = 1'h0;
    step(4);
    want = 1'h1;
    run(99, c);
    chk("pin rearm", 8'h02, 8'(c));
    want = 1'h0;
    step(4);
    t_cont(8'h80);
  endtask
  task automatic t_edge;
    int c, d;
    wr(13'h0402, 8'hC0);
    wr(13'h0403, 8'h0A);
    want = 1'h1;
    step(3);
    want = 1'h0;
    run(3, c);
    want = 1'h1;
    run(99, d);
    chk("edge burst", 8'h08, 8'(c + d));
    quiet(30);
    want = 1'h0;
    step(4);
    wr(13'h0402, 8'hE0);
    wr(13'h0403, 8'h02);
    want = 1'h1;
    quiet(12);
    want = 1'h0;
    run(99, c);
    chk("falling edge", 8'h01, 8'(c));
    wr(13'h0402, 8'hC0);
    wr(13'h0403, 8'h10);
    want = 1'h1;
    run(6, c);
    want = 1'h0;
    step(1);
    chk("edge cont", 8'h01, {7'h00, busy});
    wr(13'h0403, 8'h30);
    chk("stop", 8'h00, {6'h00, busy, sysref_out});
    quiet(20);
  endtask
  initial begin
    step(12);
    arst_n = 1'h1;
    step(1);
    t_regs();
    t_sw_burst();
    t_cont(8'h00);
    t_pin_level();
    t_edge();
    end_sim();
  end
endmodule
